// ===== design/quad_cnt_pkg.sv
package quad_cnt_pkg;

  // -------------------------------------------------------------------------
  // Widths and values
  // -------------------------------------------------------------------------
  localparam int          CNT_W       = 16;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;

  // -------------------------------------------------------------------------
  // Channel numbers
  // -------------------------------------------------------------------------
  localparam int          CH_TWO      = 2;
  localparam int          CH_THREE    = 3;
  localparam int          CH_FOUR     = 4;

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam logic [1:0]  PRIME_DONE  = 2'h3;

endpackage : quad_cnt_pkg

// ===== design/phase_evt_if.sv
`timescale 1ns/1ps
interface phase_evt_if;
  logic up;
  logic down;
  logic mult4;

  modport src (output up, output down, input mult4);
  modport snk (input up, input down, output mult4);
endinterface : phase_evt_if

// ===== design/phase_decoder.sv
`timescale 1ns/1ps
module phase_decoder
  import quad_cnt_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Encoder pins
  input  wire logic phase_primary_input,
  input  wire logic phase_secondary_input,
  // Count events
  phase_evt_if.src  evt
);

  // -------------------------------------------------------------------------
  // Pin synchronisers and previous sample
  // -------------------------------------------------------------------------
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  logic [1:0] fill_q;
  logic       up_q;
  logic       down_q;
  logic       up_d;
  logic       down_d;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      prev_q <= 2'h0;
    end else if (clk_en) begin
      meta_q <= {phase_primary_input, phase_secondary_input};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // The decode waits until the previous-sample stage holds a real pin level.
  // Otherwise the reset value of the pipeline would be taken for an edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fill_q <= 2'h0;
    end else if (clk_en && fill_q != PRIME_DONE) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // -------------------------------------------------------------------------
  // Edge decode; bit 1 is the primary phase, bit 0 the secondary phase
  // -------------------------------------------------------------------------
  always_comb begin
    up_d   = 1'b0;
    down_d = 1'b0;
    if (fill_q != PRIME_DONE) begin
      up_d   = 1'b0;
      down_d = 1'b0;
    end else if (evt.mult4) begin
      unique case ({prev_q, sync_q})
        4'b1011, 4'b1101, 4'b0100, 4'b0010: up_d   = 1'b1;
        4'b1110, 4'b0111, 4'b0001, 4'b1000: down_d = 1'b1;
        default: ;
      endcase
    end else begin
      up_d   = sync_q[1] && prev_q[1] && sync_q[0] && !prev_q[0];
      down_d = sync_q[1] && prev_q[1] && !sync_q[0] && prev_q[0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_q   <= 1'b0;
      down_q <= 1'b0;
    end else if (clk_en) begin
      up_q   <= up_d;
      down_q <= down_d;
    end
  end

  assign evt.up   = up_q;
  assign evt.down = down_q;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  sequence s_sec_rise_pri_high;
    sync_q[1] && prev_q[1] && sync_q[0] && !prev_q[0];
  endsequence

  sequence s_sec_fall_pri_high;
    sync_q[1] && prev_q[1] && !sync_q[0] && prev_q[0];
  endsequence

  AST_NORMAL_UP: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !evt.mult4 ##0 s_sec_rise_pri_high |=> up_q && !down_q)
    else $error("Normal mode missed an up count.");

  AST_NORMAL_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !evt.mult4 ##0 s_sec_fall_pri_high |=> down_q && !up_q)
    else $error("Normal mode missed a down count.");

  AST_X4_UP: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && evt.mult4 && prev_q == 2'h3 && sync_q == 2'h1 |=> up_q && !down_q)
    else $error("Multiply-by-4 missed an up count.");

  AST_X4_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && evt.mult4 && prev_q == 2'h3 && sync_q == 2'h2 |=> down_q && !up_q)
    else $error("Multiply-by-4 missed a down count.");

endmodule : phase_decoder

// ===== design/two_phase_pulse_event_counter.sv
`timescale 1ns/1ps
module two_phase_pulse_event_counter
  import quad_cnt_pkg::*;
#(
  parameter int CHANNEL_NUM = CH_TWO
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // Encoder pins
  input  wire logic              phase_primary_input,
  input  wire logic              phase_secondary_input,
  // Control
  input  wire logic              count_start,
  input  wire logic              free_run,
  input  wire logic              mult4_mode,
  // CPU access
  input  wire logic              wr_en,
  input  wire logic [CNT_W-1:0]  wr_data,
  input  wire logic              rd_en,
  output logic      [CNT_W-1:0]  rd_data,
  output logic                   rd_valid,
  // Status
  output logic      [CNT_W-1:0]  count_value,
  output logic                   irq
);

  // -------------------------------------------------------------------------
  // Edge decoder
  // -------------------------------------------------------------------------
  phase_evt_if evt ();

  // Channel four has no normal mode and always decodes all edges.
  assign evt.mult4 = mult4_mode || (CHANNEL_NUM == CH_FOUR);

  phase_decoder u_dec (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .clk_en                (clk_en),
    .phase_primary_input   (phase_primary_input),
    .phase_secondary_input (phase_secondary_input),
    .evt                   (evt)
  );

  // -------------------------------------------------------------------------
  // Counter and reload register
  // -------------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] reload_d;
  logic [CNT_W-1:0] cnt_d;
  logic             ovf;
  logic             unf;
  logic             irq_q;
  logic [CNT_W-1:0] rd_data_q;
  logic             rd_valid_q;

  assign ovf = count_start && evt.up && cnt_q == CNT_MAX;
  assign unf = count_start && evt.down && cnt_q == CNT_ZERO;

  // A write landing on the same edge as a wrap is the value reloaded.
  assign reload_d = wr_en ? wr_data : reload_q;

  always_comb begin
    cnt_d = cnt_q;
    if (wr_en && !count_start) begin
      cnt_d = wr_data;
    end else if ((ovf || unf) && !free_run) begin
      cnt_d = reload_d;
    end else if (count_start && evt.up) begin
      cnt_d = cnt_q + 16'h0001;
    end else if (count_start && evt.down) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_RST;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reload_q <= RELOAD_RST;
    end else if (clk_en) begin
      reload_q <= reload_d;
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt request
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= ovf || unf;
    end
  end

  // -------------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_q  <= CNT_RST;
      rd_valid_q <= 1'b0;
    end else if (clk_en) begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= cnt_q;
      end
    end
  end

  assign rd_data     = rd_data_q;
  assign rd_valid    = rd_valid_q;
  assign count_value = cnt_q;
  assign irq         = irq_q;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  sequence s_up_wrap;
    clk_en && count_start && evt.up && cnt_q == CNT_MAX;
  endsequence

  sequence s_down_wrap;
    clk_en && count_start && evt.down && cnt_q == CNT_ZERO;
  endsequence

  AST_IRQ_ON_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    s_up_wrap or s_down_wrap |=> irq)
    else $error("Wrap did not raise the interrupt request.");

  AST_IRQ_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    irq && $past(clk_en) |-> $past(ovf) || $past(unf))
    else $error("Interrupt request without a count event.");

  AST_READ_VALUE: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && rd_en |=> rd_valid && rd_data == $past(cnt_q))
    else $error("Read did not return the counter value.");

  AST_WRITE_STOPPED: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr_en && !count_start |=> cnt_q == $past(wr_data) && reload_q == $past(wr_data))
    else $error("Stopped write did not load counter and reload.");

  AST_WRITE_RUNNING: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr_en && count_start && !evt.up && !evt.down
    |=> cnt_q == $past(cnt_q) && reload_q == $past(wr_data))
    else $error("Running write disturbed the counter.");

  AST_RELOAD_ON_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (s_up_wrap or s_down_wrap) ##0 !free_run |=> cnt_q == $past(reload_d))
    else $error("Wrap did not reload the counter.");

  AST_HALT: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !count_start && !wr_en |=> $stable(cnt_q))
    else $error("Counter moved while stopped.");

  AST_STEP_UP: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && count_start && !wr_en && evt.up && cnt_q != CNT_MAX
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("Up event did not increment.");

  AST_FREE_WRAP_UP: assert property (@(posedge ref_clk) disable iff (rst)
    s_up_wrap ##0 free_run |=> cnt_q == CNT_ZERO)
    else $error("Free-running up count did not wrap to zero.");

  AST_FREE_WRAP_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    s_down_wrap ##0 free_run |=> cnt_q == CNT_MAX)
    else $error("Free-running down count did not wrap to all ones.");

  AST_STEP_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && count_start && !wr_en && evt.down && cnt_q != CNT_ZERO
    |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("Down event did not decrement.");

  AST_HOLD_NO_EVENT: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && count_start && !evt.up && !evt.down
    |=> $stable(cnt_q))
    else $error("Counter moved without a count event.");

  AST_WRITE_AT_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (s_up_wrap or s_down_wrap) ##0 wr_en && !free_run
    |=> cnt_q == $past(wr_data))
    else $error("Write at a wrap was not reloaded.");

  AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !ovf && !unf
    |=> !irq)
    else $error("Interrupt request without a wrap.");

  // -------------------------------------------------------------------------
  // Checks on the read path and the reload register
  // -------------------------------------------------------------------------
  AST_RELOAD_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !wr_en
    |=> $stable(reload_q))
    else $error("Reload register changed without a write.");

  AST_RD_VALID_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !rd_en
    |=> !rd_valid)
    else $error("Read valid without a read.");

  AST_RD_DATA_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !rd_en
    |=> $stable(rd_data))
    else $error("Read data changed without a read.");

endmodule : two_phase_pulse_event_counter

// ===== tb/encoder_model.sv
`timescale 1ns/1ps
module encoder_model #(
  parameter int HOLD = 5
) (
  // Clock
  input  wire logic ref_clk,
  // Encoder pins
  output logic      phase_primary_input,
  output logic      phase_secondary_input
);
  // -------------------------------------------------------------------------
  // Quadrature sequence
  // -------------------------------------------------------------------------
  // Forward order is primary/secondary 10, 11, 01, 00; each level is held
  // long enough for the two-stage synchroniser to see it.
  localparam logic [1:0] PATTERN [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  int idx = 0;

  initial begin
    {phase_primary_input, phase_secondary_input} = PATTERN[0];
  end

  task automatic step(input int n, input logic fwd);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      #10;
      idx = fwd ? (idx + 1) % 4 : (idx + 3) % 4;
      {phase_primary_input, phase_secondary_input} = PATTERN[idx];
      repeat (HOLD) @(posedge ref_clk);
      #10;
    end
  endtask : step
endmodule : encoder_model

// ===== tb/tb_two_phase_pulse_event_counter.sv
`timescale 1ns/1ps
module tb_two_phase_pulse_event_counter
  import quad_cnt_pkg::*;
;
  // -------------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------------
  logic              ref_clk;
  logic              rst;
  logic              clk_en;
  logic              phase_primary_input;
  logic              phase_secondary_input;
  logic              count_start;
  logic              free_run;
  logic              mult4_mode;
  logic              wr_en;
  logic [CNT_W-1:0]  wr_data;
  logic              rd_en;
  logic [CNT_W-1:0]  rd_data;
  logic              rd_valid;
  logic [CNT_W-1:0]  count_value;
  logic              irq;
  int                errors = 0;
  int                checked = 0;
  int                irq_cnt = 0;
  int                base;

  typedef struct {logic m4; logic fwd; logic [15:0] start; logic [15:0] exp;} row_s;
  row_s rows [4] = '{'{1'b0, 1'b1, 16'h0010, 16'h0012}, '{1'b0, 1'b0, 16'h0010, 16'h000e},
                     '{1'b1, 1'b1, 16'h0010, 16'h0018}, '{1'b1, 1'b0, 16'h0010, 16'h0008}};

  two_phase_pulse_event_counter #(.CHANNEL_NUM(CH_TWO)) i_two_phase_pulse_event_counter (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .phase_primary_input(phase_primary_input), .phase_secondary_input(phase_secondary_input),
    .count_start(count_start), .free_run(free_run), .mult4_mode(mult4_mode),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .count_value(count_value), .irq(irq));

  encoder_model i_encoder_model (
    .ref_clk(ref_clk), .phase_primary_input(phase_primary_input),
    .phase_secondary_input(phase_secondary_input));

  // -------------------------------------------------------------------------
  // Clock, interrupt tally and helpers
  // -------------------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (irq === 1'b1) begin
      irq_cnt++;
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cpu_write(input logic [15:0] v);
    @(posedge ref_clk);
    #10;
    wr_en = 1'b1;
    wr_data = v;
    @(posedge ref_clk);
    #10;
    wr_en = 1'b0;
  endtask : cpu_write

  task automatic cpu_read;
    @(posedge ref_clk);
    #10;
    rd_en = 1'b1;
    @(posedge ref_clk);
    #10;
    rd_en = 1'b0;
  endtask : cpu_read

  task automatic report_and_stop;
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // -------------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------------
  initial begin
    #500000;
    errors++;
    report_and_stop;
  end

  initial begin
    ref_clk = 1'b0; rst = 1'b1; clk_en = 1'b1; count_start = 1'b0; free_run = 1'b0;
    mult4_mode = 1'b0; wr_en = 1'b0; wr_data = 16'h0000; rd_en = 1'b0;
    repeat (12) @(posedge ref_clk);
    #10;
    rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #10;
    check("count_value", CNT_RST, count_value);
    check("rd_valid", 16'h0000, {15'h0000, rd_valid});
    foreach (rows[r]) begin
      mult4_mode = rows[r].m4;
      cpu_write(rows[r].start);
      check("count_value", rows[r].start, count_value);
      count_start = 1'b1;
      i_encoder_model.step(8, rows[r].fwd);
      count_start = 1'b0;
      cpu_read;
      check("rd_data", rows[r].exp, rd_data);
      check("rd_valid", 16'h0001, {15'h0000, rd_valid});
    end
    // Overflow with a reload value written while running.
    mult4_mode = 1'b1;
    cpu_write(16'hfffe);
    count_start = 1'b1;
    base = irq_cnt;
    i_encoder_model.step(1, 1'b1);
    check("count_value", 16'hffff, count_value);
    cpu_write(16'h1234);
    check("count_value", 16'hffff, count_value);
    i_encoder_model.step(3, 1'b1);
    check("count_value", 16'h1236, count_value);
    check("irq_count", 16'h0001, 16'(irq_cnt - base));
    // Free-running underflow wraps to all ones.
    count_start = 1'b0;
    free_run = 1'b1;
    cpu_write(16'h0001);
    count_start = 1'b1;
    base = irq_cnt;
    i_encoder_model.step(4, 1'b0);
    check("count_value", 16'hfffd, count_value);
    check("irq_count", 16'h0001, 16'(irq_cnt - base));
    // Halted counter ignores encoder edges; disabled clock ignores writes.
    count_start = 1'b0;
    i_encoder_model.step(4, 1'b1);
    check("count_value", 16'hfffd, count_value);
    clk_en = 1'b0;
    cpu_write(16'h5555);
    clk_en = 1'b1;
    check("count_value", 16'hfffd, count_value);
    // Reset in mid-run clears the counter and read path; a pin already high is no edge.
    cpu_read;
    check("rd_data", 16'hfffd, rd_data);
    count_start = 1'b1;
    rst = 1'b1;
    @(posedge ref_clk);
    #10;
    check("count_value", CNT_RST, count_value);
    check("rd_data", CNT_RST, rd_data);
    check("irq", 16'h0000, {15'h0000, irq});
    rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    #10;
    check("count_value", CNT_RST, count_value);
    i_encoder_model.step(1, 1'b1);
    check("count_value", 16'h0001, count_value);
    report_and_stop;
  end
endmodule : tb_two_phase_pulse_event_counter
